// ===== hdl/rvs_pkg.sv
// constants and types of the reset and voltage supervisor
// Operation
// - power saving drops low-voltage reset in sleep
// - disable bit turns low-voltage reset off
// - detect flag set by hardware, 7Fh clears
// - four-bit field picks sixteen detect thresholds
// - three-bit config field picks eight trip levels
// - five reset causes each reset whole chip
// - all registers but the config byte return to defaults on reset
// - power-on hold 40 ms, then load config
// - pin reset low, two slow ticks minimum
// - config bit disables the reset pin
// - writing 56h to 97h resets chip
// - watchdog counts slow rc, sleep per config
// - watchdog cleared by reset, clear bit or overflow
// - prescaler picks 400/200/100/50 ms period
// - overflow resets only when control enables it
// - code 0x off, 10 awake only, 11 always
// - clear bit drops by itself next cycle
package rvs_pkg;
  // register offsets
  localparam logic [15:0] ADDR_OPTION = 16'h0094;
  localparam logic [15:0] ADDR_FLAGS = 16'h0095;
  localparam logic [15:0] ADDR_SOFTWARE_COMMAND = 16'h0097;
  localparam logic [15:0] ADDR_LVDCTL = 16'h00BF;
  localparam logic [15:0] ADDR_PWRWD = 16'h00F7;
  localparam logic [15:0] ADDR_MISCA = 16'h00F8;
  localparam logic [15:0] ADDR_CFGH = 16'h7FFF;
  localparam logic [15:0] ADDR_STATUS = 16'h00C0;
  localparam logic [15:0] ADDR_MASK = 16'h00C1;
  localparam logic [15:0] CFG_BASE = 16'h7FFA;
  localparam logic [2:0] CFG_BYTES = 3'h6;
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] SOFTWARE_RESET_COMMAND_CODE = 8'h56;
  // field positions
  localparam int PSC_LO = 4;
  localparam int FLAG_LVD = 7;
  localparam int UNDERVOLT_DETECT_IRQ_ENABLE_BIT = 7;
  localparam int UNDERVOLT_DETECT_OUTPUT_BIT = 6;
  localparam int WATCHDOG_RESET_CONTROL_HI = 7;
  localparam int WATCHDOG_RESET_CONTROL_LO = 6;
  localparam int PSAV_BIT = 5;
  localparam int WATCHDOG_CLEAR_PULSE_BIT = 7;
  localparam int UNDERVOLT_RESET_DISABLE_BIT = 3;
  localparam int PINDIS_BIT = 6;
  localparam int LVRL_LO = 3;
  localparam int ST_LVD = 0;
  localparam int ST_WDT = 1;
  // timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int POR_WARMUP_MS = 40;
  localparam int POR_HOLD_CYC =
    (POR_WARMUP_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SRC_HZ = 80000;
  localparam int WDT_MIN_MS = 50;
  localparam logic [14:0] WDT_BASE_TICKS =
    15'(WDT_MIN_MS * SRC_HZ / 1000);
  localparam logic [1:0] PIN_MIN_TICKS = 2'h2;
  localparam logic [4:0] HOLD_CYC = 5'h10;

  typedef enum logic [2:0] {
    PM_FAST, PM_SLOW, PM_IDLE, PM_HALT, PM_STOP
  } rvs_mode_type;

  typedef struct packed {
    logic por;
    logic pin;
    logic sw;
    logic wdt;
    logic low_voltage_reset;
  } rvs_cause_type;
endpackage : rvs_pkg

// ===== hdl/rvs_supervisor.sv
// reset sequencer, undervoltage supervision and watchdog
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module rvs_supervisor
  import rvs_pkg::*;
#(
  parameter int POR_HOLD_CYCLES = POR_HOLD_CYC
) (
  // clock and power-on reset
  input wire logic ref_clk,
  input wire logic rst,
  // register port
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // chip environment
  input wire logic pin_reset_n,
  input wire logic slow_rc_tick,
  input wire rvs_mode_type power_mode,
  input wire logic global_undervolt_irq_enable,
  // analog comparators
  input wire logic undervolt_reset_below,
  input wire logic undervolt_detect_below,
  output logic [2:0] undervolt_reset_level,
  output logic [3:0] undervolt_detect_level,
  output logic undervolt_reset_armed,
  // config memory read port
  output logic [15:0] cfg_addr,
  input wire logic [7:0] cfg_data,
  // reset and interrupt outputs
  output logic chip_reset,
  output rvs_cause_type reset_cause,
  output logic undervolt_irq,
  output logic irq
);

  typedef enum logic [1:0] {
    SQ_POR, SQ_LOAD, SQ_HOLD, SQ_RUN
  } rvs_state_type;

  function automatic logic hit(
    input logic [15:0] a,
    input logic [15:0] b
  );
    hit = (a == b);
  endfunction : hit

  rvs_state_type state;
  rvs_state_type next_state;
  logic [31:0] por_cnt;
  logic [4:0] hold_cnt;
  logic [2:0] load_cnt;
  logic [7:0] option_select;
  logic [7:0] peripheral_interrupt_flags;
  logic [7:0] voltage_detect_control;
  logic [7:0] power_watchdog_control;
  logic [7:0] misc_control_a;
  logic [7:0] config_word_high;
  logic [7:0] status;
  logic [7:0] mask;
  logic [14:0] wdt_cnt;
  logic [1:0] pin_cnt;
  logic lvd_below_d;
  logic [7:0] next_rdata;

  // register decode
  wire run = (state == SQ_RUN);
  wire sfr_rst = rst | ~run;
  wire wr_en = reg_wr & run;
  wire wr_opt = wr_en & hit(reg_addr, ADDR_OPTION);
  wire wr_flg = wr_en & hit(reg_addr, ADDR_FLAGS);
  wire wr_sw = wr_en & hit(reg_addr, ADDR_SOFTWARE_COMMAND);
  wire wr_lvd = wr_en & hit(reg_addr, ADDR_LVDCTL);
  wire wr_pwd = wr_en & hit(reg_addr, ADDR_PWRWD);
  wire wr_msc = wr_en & hit(reg_addr, ADDR_MISCA);
  wire wr_sts = wr_en & hit(reg_addr, ADDR_STATUS);
  wire wr_msk = wr_en & hit(reg_addr, ADDR_MASK);

  // control fields
  wire [1:0] watchdog_period_select =
    option_select[PSC_LO+1:PSC_LO];
  wire [1:0] watchdog_reset_control =
    power_watchdog_control[WATCHDOG_RESET_CONTROL_HI:WATCHDOG_RESET_CONTROL_LO];
  wire power_saving_enable = power_watchdog_control[PSAV_BIT];
  wire watchdog_clear_pulse = misc_control_a[WATCHDOG_CLEAR_PULSE_BIT];
  wire undervolt_reset_disable = misc_control_a[UNDERVOLT_RESET_DISABLE_BIT];
  wire undervolt_detect_irq_enable =
    voltage_detect_control[UNDERVOLT_DETECT_IRQ_ENABLE_BIT];
  wire pin_reset_disable = config_word_high[PINDIS_BIT];
  wire undervolt_detect_flag =
    peripheral_interrupt_flags[FLAG_LVD];
  wire undervolt_detect_output = undervolt_detect_below;
  wire awake = (power_mode == PM_FAST) | (power_mode == PM_SLOW);

  // low-voltage reset arming
  assign undervolt_reset_armed = ~undervolt_reset_disable
    & ~(power_saving_enable & ~awake);
  assign undervolt_reset_level =
    config_word_high[LVRL_LO+2:LVRL_LO];
  assign undervolt_detect_level =
    voltage_detect_control[3:0];
  wire lvr_trip = undervolt_reset_armed & undervolt_reset_below;

  // pin reset filter on slow rc ticks
  wire pin_low = ~pin_reset_n & ~pin_reset_disable;
  wire pin_trip = (pin_cnt == PIN_MIN_TICKS);

  always_ff @(posedge ref_clk) begin
    if (rst || !pin_low) begin
      pin_cnt <= 2'h0;
    end else if (slow_rc_tick && !pin_trip) begin
      pin_cnt <= pin_cnt + 2'h1;
    end
  end

  // watchdog
  wire [14:0] wdt_limit =
    WDT_BASE_TICKS << (~watchdog_period_select);
  wire wdt_run = awake | (watchdog_reset_control == 2'h3);
  wire wdt_step = slow_rc_tick & wdt_run & run;
  wire wdt_ovf = wdt_step & (wdt_cnt == wdt_limit - 15'h1);
  wire wdt_rst_en = watchdog_reset_control[1]
    & (watchdog_reset_control[0] | awake);

  always_ff @(posedge ref_clk) begin
    if (sfr_rst || watchdog_clear_pulse || wdt_ovf) begin
      wdt_cnt <= 15'h0;
    end else if (wdt_step) begin
      wdt_cnt <= wdt_cnt + 15'h1;
    end
  end

  // reset causes
  wire sw_trip = wr_sw & (reg_wdata == SOFTWARE_RESET_COMMAND_CODE);
  rvs_cause_type cause;
  assign cause.por = 1'b0;
  assign cause.pin = pin_trip;
  assign cause.sw = sw_trip;
  assign cause.wdt = wdt_ovf & wdt_rst_en;
  assign cause.low_voltage_reset = lvr_trip;
  wire any_cause = |cause;

  // sequencer
  always_comb begin
    next_state = state;
    case (state)
      SQ_POR: begin
        if (por_cnt >= 32'(POR_HOLD_CYCLES) - 32'h1) begin
          next_state = SQ_LOAD;
        end
      end
      SQ_LOAD: begin
        if (load_cnt == CFG_BYTES) begin
          next_state = SQ_RUN;
        end
      end
      SQ_HOLD: begin
        if (hold_cnt == HOLD_CYC && !any_cause) begin
          next_state = SQ_RUN;
        end
      end
      SQ_RUN: begin
        if (any_cause) begin
          next_state = SQ_HOLD;
        end
      end
      default: begin
        next_state = SQ_POR;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= SQ_POR;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst || state != SQ_POR) begin
      por_cnt <= 32'h0;
    end else begin
      por_cnt <= por_cnt + 32'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (state != SQ_HOLD || any_cause) begin
      hold_cnt <= 5'h0;
    end else if (hold_cnt != HOLD_CYC) begin
      hold_cnt <= hold_cnt + 5'h1;
    end
  end

  // config load, last six bytes, data one cycle later
  assign cfg_addr = CFG_BASE + {13'h0, load_cnt};

  always_ff @(posedge ref_clk) begin
    if (state != SQ_LOAD) begin
      load_cnt <= 3'h0;
    end else if (load_cnt != CFG_BYTES) begin
      load_cnt <= load_cnt + 3'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      config_word_high <= RST_BYTE;
    end else if (state == SQ_LOAD && load_cnt == CFG_BYTES) begin
      config_word_high <= cfg_data;
    end
  end

  // reset outputs
  assign chip_reset = ~run;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reset_cause <= '{por: 1'b1, default: 1'b0};
    end else if (run && any_cause) begin
      reset_cause <= cause;
    end
  end

  // software registers, defaults while reset held
  always_ff @(posedge ref_clk) begin
    if (sfr_rst) begin
      option_select <= RST_BYTE;
      power_watchdog_control <= RST_BYTE;
      voltage_detect_control <= RST_BYTE;
      mask <= RST_BYTE;
    end else begin
      if (wr_opt) begin
        option_select <= reg_wdata;
      end
      if (wr_pwd) begin
        power_watchdog_control <= reg_wdata;
      end
      if (wr_lvd) begin
        voltage_detect_control <= {reg_wdata[7], 3'h0,
          reg_wdata[3:0]};
      end
      if (wr_msk) begin
        mask <= reg_wdata;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sfr_rst) begin
      misc_control_a <= RST_BYTE;
    end else if (wr_msc) begin
      misc_control_a <= reg_wdata;
    end else begin
      misc_control_a[WATCHDOG_CLEAR_PULSE_BIT] <= 1'b0;
    end
  end

  // undervoltage detect flag and status
  wire lvd_event = undervolt_detect_below & ~lvd_below_d;
  wire lvd_clr = wr_flg & ~reg_wdata[FLAG_LVD];
  wire [7:0] events = {6'h0, wdt_ovf, lvd_event};
  wire [7:0] sts_clr = wr_sts ? reg_wdata : 8'h00;

  always_ff @(posedge ref_clk) begin
    if (sfr_rst) begin
      lvd_below_d <= 1'b0;
      peripheral_interrupt_flags <= RST_BYTE;
      status <= RST_BYTE;
    end else begin
      lvd_below_d <= undervolt_detect_below;
      if (lvd_event) begin
        peripheral_interrupt_flags[FLAG_LVD] <= 1'b1;
      end else if (lvd_clr) begin
        peripheral_interrupt_flags[FLAG_LVD] <= 1'b0;
      end
      status <= (status & ~sts_clr) | events;
    end
  end

  assign undervolt_irq = undervolt_detect_flag
    & undervolt_detect_irq_enable
    & global_undervolt_irq_enable;
  assign irq = |(status & mask);

  // read mux
  wire [7:0] lvd_rd = {undervolt_detect_irq_enable,
    undervolt_detect_output, 2'h0,
    voltage_detect_control[3:0]};
  assign next_rdata =
    hit(reg_addr, ADDR_OPTION) ? option_select :
    hit(reg_addr, ADDR_FLAGS) ? peripheral_interrupt_flags :
    hit(reg_addr, ADDR_LVDCTL) ? lvd_rd :
    hit(reg_addr, ADDR_PWRWD) ? power_watchdog_control :
    hit(reg_addr, ADDR_MISCA) ? misc_control_a :
    hit(reg_addr, ADDR_CFGH) ? config_word_high :
    hit(reg_addr, ADDR_STATUS) ? status :
    hit(reg_addr, ADDR_MASK) ? mask : 8'h00;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  AST_SOFTWARE_RESET_COMMAND: assert property (
    sw_trip |=> chip_reset && reset_cause.sw)
    else $error("software code did not reset");
  AST_CLR_PULSE: assert property (
    watchdog_clear_pulse && !wr_msc |=> !watchdog_clear_pulse)
    else $error("watchdog clear bit stuck");
  AST_WDT_CLR: assert property (
    watchdog_clear_pulse |=> wdt_cnt == 15'h0)
    else $error("watchdog not cleared");
  AST_LVR_OFF: assert property (
    undervolt_reset_disable |-> !lvr_trip)
    else $error("disabled undervolt reset fired");
  AST_PSAV: assert property (
    power_saving_enable && !awake |-> !undervolt_reset_armed)
    else $error("undervolt reset armed in sleep");
  AST_FLAG: assert property (
    lvd_event && run |=> undervolt_detect_flag)
    else $error("detect flag not set");
  AST_FLAG_CLR: assert property (
    lvd_clr && !lvd_event && run |=> !undervolt_detect_flag)
    else $error("detect flag not cleared");
  AST_IRQ: assert property (
    !global_undervolt_irq_enable |-> !undervolt_irq)
    else $error("irq without global enable");
  AST_PIN_DIS: assert property (
    pin_reset_disable |=> pin_cnt == 2'h0)
    else $error("disabled pin counted");
  AST_POR: assert property (
    $past(state) == SQ_POR && state == SQ_LOAD
      |-> $past(por_cnt) == 32'(POR_HOLD_CYCLES) - 32'h1)
    else $error("warm-up length wrong");
  AST_WDT_GATE: assert property (
    wdt_ovf && !watchdog_reset_control[1] |-> !cause.wdt)
    else $error("watchdog reset while disabled");
  AST_CAUSE: assert property (
    run && any_cause |=> chip_reset)
    else $error("reset cause did not reset chip");
  AST_SFR_DEF: assert property (
    !run |=> option_select == RST_BYTE && power_watchdog_control == RST_BYTE
      && misc_control_a == RST_BYTE && mask == RST_BYTE)
    else $error("register not at default in reset");
  AST_PIN_SHORT: assert property (
    pin_low && pin_cnt == 2'h0 |=> !pin_trip)
    else $error("pin reset after one tick");
  AST_CFG_LOAD: assert property (
    state == SQ_LOAD && load_cnt == CFG_BYTES |=> config_word_high == $past(cfg_data))
    else $error("config word not loaded");
  AST_WDT_SLEEP: assert property (
    wdt_ovf && !awake && watchdog_reset_control != 2'h3 |-> !cause.wdt)
    else $error("watchdog reset in sleep");

  COV_SW: cover property (run ##1 sw_trip);
  COV_WDT: cover property (cause.wdt);
  COV_PIN: cover property (run && pin_trip);
  COV_LVD: cover property (lvd_event ##[1:20] lvd_clr);
  COV_WDT_SLEEP: cover property (cause.wdt && !awake);

endmodule : rvs_supervisor
`default_nettype wire

// ===== verification/rvs_tb.sv
// self-checking bench of the reset and voltage supervisor
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import rvs_pkg::*;
  localparam int HOLD = 20;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic pin_n = 1'b1;
  logic tick = 1'b0;
  rvs_mode_type mode = PM_FAST;
  logic gie = 1'b1;
  logic lvr_below = 1'b0;
  logic lvd_below = 1'b0;
  logic [2:0] lvr_lvl;
  logic [3:0] lvd_lvl;
  logic armed;
  logic [15:0] cfg_addr;
  logic [7:0] cfg_data = 8'h00;
  logic [7:0] cfg_high = 8'h28;
  logic chip_reset;
  rvs_cause_type cause;
  logic uv_irq;
  logic irq;
  int error_cnt = 0;
  int checks_done = 0;

  always #20 ref_clk = ~ref_clk;

  // config memory answers one cycle after the address
  always @(posedge ref_clk) cfg_data <= (cfg_addr == ADDR_CFGH) ? cfg_high : 8'h00;

  rvs_supervisor #(.POR_HOLD_CYCLES(HOLD)) u_dut (
    .ref_clk(ref_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pin_reset_n(pin_n), .slow_rc_tick(tick),
    .power_mode(mode), .global_undervolt_irq_enable(gie),
    .undervolt_reset_below(lvr_below), .undervolt_detect_below(lvd_below),
    .undervolt_reset_level(lvr_lvl), .undervolt_detect_level(lvd_lvl),
    .undervolt_reset_armed(armed), .cfg_addr(cfg_addr), .cfg_data(cfg_data),
    .chip_reset(chip_reset), .reset_cause(cause), .undervolt_irq(uv_irq), .irq(irq)
  );

  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk8

  task automatic chk1(input string what, input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask : chk1

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [7:0] exp, input string what);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk8(what, exp, reg_rdata);
  endtask : rd

  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      tick <= 1'b1;
      @(posedge ref_clk);
      tick <= 1'b0;
    end
    #1;
  endtask : ticks

  task automatic wait_run;
    int i;
    i = 0;
    while (chip_reset !== 1'b0 && i < 300) begin
      @(posedge ref_clk);
      #1;
      i++;
    end
    chk1("chip_reset", 1'b0, chip_reset);
  endtask : wait_run

  task automatic results;
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results

  initial begin
    #2400000;
    error_cnt++;
    results();
  end

  initial begin
    logic [15:0] sfr [5];
    sfr = '{ADDR_OPTION, ADDR_FLAGS, ADDR_LVDCTL, ADDR_PWRWD, ADDR_MISCA};
    cyc(8);
    rst <= 1'b0;
    cyc(HOLD);
    #1;
    chk1("warm-up hold", 1'b1, chip_reset);
    wait_run();
    chk1("por cause", 1'b1, cause.por);
    chk8("trip level", 8'h05, {5'h00, lvr_lvl});
    for (int i = 0; i < 5; i++) rd(sfr[i], 8'h00, "default");
    // detector, flag and interrupts
    wr(ADDR_LVDCTL, 8'hFA);
    rd(ADDR_LVDCTL, 8'h8A, "detect ctl");
    chk8("detect level", 8'h0A, {4'h0, lvd_lvl});
    wr(ADDR_MASK, 8'h01);
    @(posedge ref_clk) lvd_below <= 1'b1;
    cyc(3);
    rd(ADDR_FLAGS, 8'h80, "flags");
    rd(ADDR_LVDCTL, 8'hCA, "detect out");
    chk1("detect irq", 1'b1, uv_irq);
    chk1("irq", 1'b1, irq);
    @(posedge ref_clk) gie <= 1'b0;
    #1;
    chk1("detect irq gated", 1'b0, uv_irq);
    wr(ADDR_LVDCTL, 8'h0A);
    @(posedge ref_clk) gie <= 1'b1;
    #1;
    chk1("detect irq local", 1'b0, uv_irq);
    wr(ADDR_MASK, 8'h00);
    chk1("irq masked", 1'b0, irq);
    wr(ADDR_MASK, 8'h01);
    wr(ADDR_STATUS, 8'h01);
    chk1("irq cleared", 1'b0, irq);
    wr(ADDR_FLAGS, 8'h7F);
    rd(ADDR_FLAGS, 8'h00, "flags cleared");
    @(posedge ref_clk) lvd_below <= 1'b0;
    #1;
    // low-voltage reset arming
    chk1("armed", 1'b1, armed);
    wr(ADDR_MISCA, 8'h08);
    chk1("armed off", 1'b0, armed);
    wr(ADDR_MISCA, 8'h00);
    wr(ADDR_PWRWD, 8'h20);
    chk1("armed awake", 1'b1, armed);
    for (int m = 1; m < 5; m++) begin
      @(posedge ref_clk) mode <= rvs_mode_type'(m);
      #1;
      chk1("armed by mode", m < 2, armed);
    end
    wr(ADDR_PWRWD, 8'h00);
    chk1("armed no saving", 1'b1, armed);
    @(posedge ref_clk) mode <= PM_FAST;
    wr(ADDR_MISCA, 8'h08);
    @(posedge ref_clk) lvr_below <= 1'b1;
    cyc(4);
    #1;
    chk1("no low-voltage reset", 1'b0, chip_reset);
    wr(ADDR_MISCA, 8'h00);
    cyc(2);
    #1;
    chk1("low-voltage reset", 1'b1, chip_reset);
    chk1("lvr cause", 1'b1, cause.low_voltage_reset);
    @(posedge ref_clk) lvr_below <= 1'b0;
    wait_run();
    // software command
    wr(ADDR_PWRWD, 8'h40);
    wr(ADDR_SOFTWARE_COMMAND, 8'h55);
    cyc(2);
    #1;
    chk1("wrong command", 1'b0, chip_reset);
    wr(ADDR_SOFTWARE_COMMAND, 8'h56);
    chk1("sw reset", 1'b1, chip_reset);
    chk1("sw cause", 1'b1, cause.sw);
    wait_run();
    rd(ADDR_PWRWD, 8'h00, "pwrwd after reset");
    // reset pin
    @(posedge ref_clk) pin_n <= 1'b0;
    ticks(1);
    cyc(3);
    #1;
    chk1("short pin pulse", 1'b0, chip_reset);
    @(posedge ref_clk) pin_n <= 1'b1;
    cyc(2);
    @(posedge ref_clk) pin_n <= 1'b0;
    ticks(2);
    cyc(2);
    #1;
    chk1("pin reset", 1'b1, chip_reset);
    chk1("pin cause", 1'b1, cause.pin);
    @(posedge ref_clk) pin_n <= 1'b1;
    wait_run();
    // watchdog
    wr(ADDR_OPTION, 8'h30);
    ticks(4010);
    chk1("wdt off", 1'b0, chip_reset);
    rd(ADDR_STATUS, 8'h02, "overflow event");
    wr(ADDR_PWRWD, 8'h80);
    wr(ADDR_MISCA, 8'h80);
    rd(ADDR_MISCA, 8'h00, "clear bit");
    ticks(3990);
    wr(ADDR_MISCA, 8'h80);
    ticks(3990);
    chk1("wdt cleared", 1'b0, chip_reset);
    @(posedge ref_clk) mode <= PM_IDLE;
    ticks(200);
    chk1("wdt asleep", 1'b0, chip_reset);
    @(posedge ref_clk) mode <= PM_FAST;
    ticks(9);
    chk1("wdt not yet", 1'b0, chip_reset);
    ticks(1);
    chk1("wdt reset", 1'b1, chip_reset);
    chk1("wdt cause", 1'b1, cause.wdt);
    wait_run();
    wr(ADDR_OPTION, 8'h20);
    wr(ADDR_PWRWD, 8'hC0);
    @(posedge ref_clk) mode <= PM_IDLE;
    ticks(7999);
    chk1("wdt early", 1'b0, chip_reset);
    ticks(1);
    chk1("wdt sleep reset", 1'b1, chip_reset);
    @(posedge ref_clk) mode <= PM_FAST;
    wait_run();
    // pin disabled by config
    cfg_high <= 8'h68;
    @(posedge ref_clk) rst <= 1'b1;
    cyc(8);
    rst <= 1'b0;
    wait_run();
    chk1("por cause again", 1'b1, cause.por);
    rd(ADDR_OPTION, 8'h00, "option after por");
    @(posedge ref_clk) pin_n <= 1'b0;
    ticks(4);
    cyc(2);
    #1;
    chk1("pin ignored", 1'b0, chip_reset);
    results();
  end
endmodule : testbench
`default_nettype wire
